// File: logic/qsw_cfg.svh
`ifndef QSW_CFG_SVH
`define QSW_CFG_SVH

// Register port geometry
`define QSW_ADDR_W 6
`define QSW_DATA_W 16
`define QSW_QUEUE_DEPTH 16
`define QSW_PTR_W 4
`define QSW_CNT_W 5

// Word offsets on the register port
`define QSW_RX_BASE 6'h00
`define QSW_TX_BASE 6'h10
`define QSW_CTRL0_OFS 6'h20
`define QSW_CTRL1_OFS 6'h21
`define QSW_CTRL2_OFS 6'h22
`define QSW_CTRL3_OFS 6'h23
`define QSW_STAT_OFS 6'h24

// Control 0: word length, clock shape, mode
`define QSW_BITS_LSB 0
`define QSW_BITS_MSB 3
`define QSW_CLOCK_PHASE_BIT_BIT 4
`define QSW_CLOCK_POLARITY_BIT_BIT 5
`define QSW_MASTER_SELECT_BIT_BIT 7
`define QSW_BITS_RST 4'h8

// Control 1: port enable
`define QSW_PE_BIT 0

// Control 2: queue pointers and wrap
`define QSW_NEWQ_LSB 0
`define QSW_NEWQ_MSB 3
`define QSW_ENDQ_LSB 8
`define QSW_ENDQ_MSB 11
`define QSW_WRAP_TARGET_SELECT_BIT 13
`define QSW_WRAP_ENABLE_BIT 14
`define QSW_IRQEN_BIT 15

// Control 3: halt request
`define QSW_HALT_BIT 0

// Status
`define QSW_DONE_BIT 0
`define QSW_HALTED_BIT 1
`define QSW_CPTQ_LSB 8
`define QSW_CPTQ_MSB 11

// Word length limits
`define QSW_MIN_BITS 5'h08
`define QSW_MAX_BITS 5'h10

`endif

// File: logic/qsw_pkg.sv
`include "qsw_cfg.svh"

package qsw_pkg;

   typedef enum logic [1:0] {
      QSW_ST_OFF,
      QSW_ST_LOAD,
      QSW_ST_READY,
      QSW_ST_HALT
   } qsw_state_e;

   typedef logic [`QSW_PTR_W-1:0] qsw_ptr_t;
   typedef logic [`QSW_DATA_W-1:0] qsw_word_t;
   typedef logic [`QSW_CNT_W-1:0] qsw_cnt_t;

endpackage : qsw_pkg

// File: logic/qsw_slave.sv
`timescale 1ns/1ps
`include "qsw_cfg.svh"

// How it works
// R1: Reaching the last entry always sets the done flag, wrap or not.
// R2: Interrupt is raised while done flag and buffered interrupt enable are both set.
// R3: Without wrap, end of queue clears port enable and stops.
// R4: With wrap, the queue keeps cycling and port enable stays set.
// R5: Interrupt enable is buffered; clearing it later keeps a pending request.
// R6: Done flag clears only after status read with flag set, then zero write.
// R7: In wrap, received words overwrite older receive entries freely.
// R8: After wrap is cleared, next end of queue sets flag, clears enable, stops.
// R9: Halt request finishes the current word, then halts.
// R10: Clearing port enable stops at once, aborting a word in progress.
// R11: As slave the port only answers transfers begun by the master.
// R12: Select low with port enabled and slave mode starts at new pointer.
// R13: Entry command bits are ignored; only select zero is used, as input.
// R14: Full word under select is stored, then the next entry takes bits.
// R15: Without wrap, after the end entry further bits are discarded.
// R16: With wrap, storing resumes at entry zero or the new pointer.
// R17: Master leaves about one microsecond between words for prefetch.
// R18: Global bit count sets word length; one bit per clock while selected.
// R19: A partial word is kept and resumed at the next selection.
// R20: Full word stores data, records completed pointer, advances, loads next.
// R21: Transmit word leaves MSB first; phase and polarity pick the edges.
// R22: Bits sent equal bits received per entry, until end of queue.
// R23: After each entry the end pointer is compared with the completed one.
// R24: Word length defaults to eight and spans eight through sixteen.
// R25: Serial clock and select are synchronised and edge detected first.
// R26: Interrupt output is done flag AND buffered interrupt enable.
module qsw_slave
   import qsw_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [`QSW_ADDR_W-1:0] i_addr,
   input wire logic [`QSW_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [`QSW_DATA_W-1:0] o_rdata,
   input wire logic i_sck,
   input wire logic i_sel_n,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe,
   output logic o_irq,
   output logic o_port_enable
);

   qsw_word_t rx_mem [`QSW_QUEUE_DEPTH], tx_mem [`QSW_QUEUE_DEPTH];

   // Configuration
   logic [3:0] bits_q;
   logic clock_phase_bit_q, clock_polarity_bit_q, master_select_bit_q, pe_q, wrap_target_select_q, wrap_enable_q, irqen_q, halt_req_q, newq_wr_q;
   qsw_ptr_t newq_q, endq_q;
   // Status
   logic done_q, irqen_buf_q, clr_armed_q;
   qsw_ptr_t cptq_q;
   // Serial engine
   qsw_state_e st_q;
   qsw_ptr_t wp_q;
   qsw_cnt_t cnt_q;
   qsw_word_t tx_q, rx_q, rdata_q;
   logic pend_q, miso_q, miso_oe_q, irq_q;
   // Synchronisers
   logic sck_s1_q, sck_s2_q, sck_s3_q;
   logic sel_s1_q, sel_s2_q, sel_s3_q;
   logic mosi_s1_q, mosi_s2_q;

   logic sck_rise, sck_fall, lead_edge, trail_edge, sample_edge, drive_edge;
   logic selected, sel_fall, word_done, at_end, done_set, slave_run;
   logic wr_stat, rd_stat, wr_ctrl1;
   qsw_cnt_t nbits, cnt_inc;

   // Values 1..7 are not meaningful word lengths; treated as the minimum
   function automatic qsw_cnt_t word_len(input logic [3:0] f);
      qsw_cnt_t n;
      n = {1'b0, f};
      if (f == 4'h0) begin
         word_len = `QSW_MAX_BITS;
      end else if (n < `QSW_MIN_BITS) begin
         word_len = `QSW_MIN_BITS;
      end else begin
         word_len = n;
      end
   endfunction : word_len

   function automatic logic hit(input logic [`QSW_ADDR_W-1:0] a,
                                input logic [`QSW_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
         sel_s1_q <= 1'b1;
         sel_s2_q <= 1'b1;
         sel_s3_q <= 1'b1;
         mosi_s1_q <= 1'b0;
         mosi_s2_q <= 1'b0;
      end else begin
         sck_s1_q <= i_sck; // see R25
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         sel_s1_q <= i_sel_n;
         sel_s2_q <= sel_s1_q;
         sel_s3_q <= sel_s2_q;
         mosi_s1_q <= i_mosi;
         mosi_s2_q <= mosi_s1_q;
      end
   end

   assign sck_rise = sck_s2_q & ~sck_s3_q; // see R25
   assign sck_fall = ~sck_s2_q & sck_s3_q;
   assign lead_edge = clock_polarity_bit_q ? sck_fall : sck_rise; // see R21
   assign trail_edge = clock_polarity_bit_q ? sck_rise : sck_fall;
   assign sample_edge = clock_phase_bit_q ? trail_edge : lead_edge;
   assign drive_edge = clock_phase_bit_q ? lead_edge : trail_edge;
   assign selected = ~sel_s2_q; // see R13
   assign sel_fall = ~sel_s2_q & sel_s3_q;
   assign nbits = word_len(bits_q); // see R18
   assign cnt_inc = cnt_q + 5'h01;
   assign slave_run = pe_q & ~master_select_bit_q; // see R11
   assign word_done = (st_q == QSW_ST_READY) && selected && sample_edge && (cnt_inc >= nbits);
   assign at_end = (wp_q == endq_q); // see R23
   assign done_set = slave_run && word_done && at_end; // see R1
   assign wr_stat = i_wr && hit(i_addr, `QSW_STAT_OFS);
   assign rd_stat = i_rd && hit(i_addr, `QSW_STAT_OFS);
   assign wr_ctrl1 = i_wr && hit(i_addr, `QSW_CTRL1_OFS);

   // Software configuration
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         bits_q <= `QSW_BITS_RST; // see R24
         clock_phase_bit_q <= 1'b0;
         clock_polarity_bit_q <= 1'b0;
         master_select_bit_q <= 1'b0;
         newq_q <= '0;
         endq_q <= '0;
         wrap_target_select_q <= 1'b0;
         wrap_enable_q <= 1'b0;
         irqen_q <= 1'b0;
         halt_req_q <= 1'b0;
      end else if (i_wr) begin
         if (hit(i_addr, `QSW_CTRL0_OFS)) begin
            bits_q <= i_wdata[`QSW_BITS_MSB:`QSW_BITS_LSB];
            clock_phase_bit_q <= i_wdata[`QSW_CLOCK_PHASE_BIT_BIT];
            clock_polarity_bit_q <= i_wdata[`QSW_CLOCK_POLARITY_BIT_BIT];
            master_select_bit_q <= i_wdata[`QSW_MASTER_SELECT_BIT_BIT];
         end
         if (hit(i_addr, `QSW_CTRL2_OFS)) begin
            newq_q <= i_wdata[`QSW_NEWQ_MSB:`QSW_NEWQ_LSB];
            endq_q <= i_wdata[`QSW_ENDQ_MSB:`QSW_ENDQ_LSB];
            wrap_target_select_q <= i_wdata[`QSW_WRAP_TARGET_SELECT_BIT];
            wrap_enable_q <= i_wdata[`QSW_WRAP_ENABLE_BIT]; // see R8
            irqen_q <= i_wdata[`QSW_IRQEN_BIT];
         end
         if (hit(i_addr, `QSW_CTRL3_OFS)) begin
            halt_req_q <= i_wdata[`QSW_HALT_BIT];
         end
      end
   end

   // Transmit area is filled by software only
   always_ff @(posedge i_ref_clk) begin
      if (i_wr && (i_addr[`QSW_ADDR_W-1:`QSW_PTR_W] == `QSW_TX_BASE >> `QSW_PTR_W)) begin
         tx_mem[i_addr[`QSW_PTR_W-1:0]] <= i_wdata;
      end
   end

   // Receive area is filled by the serial engine only
   always_ff @(posedge i_ref_clk) begin
      if (word_done && slave_run) begin
         rx_mem[wp_q] <= {rx_q[`QSW_DATA_W-2:0], mosi_s2_q}; // see R7, R14, R20
      end
   end

   // New pointer rewrite is remembered until the next selection
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         newq_wr_q <= 1'b0;
      end else if (i_wr && hit(i_addr, `QSW_CTRL2_OFS)) begin
         newq_wr_q <= 1'b1;
      end else if (st_q == QSW_ST_OFF || (st_q == QSW_ST_READY && sel_fall && cnt_q == '0)) begin
         newq_wr_q <= 1'b0;
      end
   end

   // Port enable: set by software, cleared by software or at end of queue without wrap
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         pe_q <= 1'b0;
      end else if (done_set && !wrap_enable_q) begin
         pe_q <= 1'b0; // see R3, R8
      end else if (wr_ctrl1) begin
         pe_q <= i_wdata[`QSW_PE_BIT]; // see R10
      end
   end

   // Done flag; a set in the clearing cycle wins
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         done_q <= 1'b0;
         clr_armed_q <= 1'b0;
      end else begin
         if (done_set) begin
            done_q <= 1'b1; // see R1, R4
         end else if (wr_stat && clr_armed_q && !i_wdata[`QSW_DONE_BIT]) begin
            done_q <= 1'b0; // see R6
         end
         if (rd_stat && done_q) begin
            clr_armed_q <= 1'b1; // see R6
         end else if (wr_stat) begin
            clr_armed_q <= 1'b0;
         end
      end
   end

   // Enable captured at each flag assertion, so a late clear keeps the request
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         irqen_buf_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         if (done_set) begin
            irqen_buf_q <= irqen_q | (done_q & irqen_buf_q); // see R5
         end
         irq_q <= done_q & irqen_buf_q; // see R2, R26
      end
   end

   // Serial engine
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         st_q <= QSW_ST_OFF;
         wp_q <= '0;
         cptq_q <= '0;
         cnt_q <= '0;
         tx_q <= '0;
         rx_q <= '0;
         pend_q <= 1'b0;
         miso_q <= 1'b0;
      end else if (!slave_run) begin
         st_q <= QSW_ST_OFF; // see R10
         cnt_q <= '0;
         pend_q <= 1'b0;
      end else begin
         case (st_q)
            QSW_ST_OFF: begin
               wp_q <= newq_q; // see R12
               st_q <= QSW_ST_LOAD;
            end
            QSW_ST_LOAD: begin
               tx_q <= tx_mem[wp_q]; // see R20
               miso_q <= tx_mem[wp_q][`QSW_DATA_W-1];
               pend_q <= 1'b0;
               st_q <= QSW_ST_READY;
            end
            QSW_ST_READY: begin
               if (cnt_q == '0 && halt_req_q) begin
                  st_q <= QSW_ST_HALT; // see R9
               end else if (cnt_q == '0 && sel_fall && newq_wr_q) begin
                  wp_q <= newq_q; // see R12
                  st_q <= QSW_ST_LOAD;
               end else if (selected && sample_edge) begin
                  rx_q <= {rx_q[`QSW_DATA_W-2:0], mosi_s2_q}; // see R18, R19
                  if (word_done) begin
                     cnt_q <= '0;
                     cptq_q <= wp_q; // see R20
                     if (!at_end) begin
                        wp_q <= wp_q + 4'h1; // see R14
                        st_q <= QSW_ST_LOAD;
                     end else if (wrap_enable_q) begin
                        wp_q <= wrap_target_select_q ? newq_q : 4'h0; // see R4, R16
                        st_q <= QSW_ST_LOAD;
                     end else begin
                        st_q <= QSW_ST_OFF; // see R15
                     end
                  end else begin
                     cnt_q <= cnt_inc;
                     pend_q <= 1'b1;
                  end
               end else if (selected && drive_edge) begin
                  if (clock_phase_bit_q) begin
                     miso_q <= tx_q[`QSW_DATA_W-1]; // see R21, R22
                     tx_q <= {tx_q[`QSW_DATA_W-2:0], 1'b0};
                  end else if (pend_q) begin
                     miso_q <= tx_q[`QSW_DATA_W-2]; // see R21, R22
                     tx_q <= {tx_q[`QSW_DATA_W-2:0], 1'b0};
                     pend_q <= 1'b0;
                  end
               end
            end
            QSW_ST_HALT: begin
               if (!halt_req_q) begin
                  st_q <= QSW_ST_READY;
               end
            end
            default: begin
               st_q <= QSW_ST_OFF;
            end
         endcase
      end
   end

   // Drive data only while selected as a running slave
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         miso_oe_q <= 1'b0;
      end else begin
         miso_oe_q <= slave_run && selected && (st_q != QSW_ST_OFF); // see R11, R13
      end
   end

   // Read data stand for one cycle after each read cycle, zero otherwise
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         rdata_q <= '0;
      end else if (!i_rd) begin
         rdata_q <= '0;
      end else if (i_addr[`QSW_ADDR_W-1:`QSW_PTR_W] == `QSW_RX_BASE >> `QSW_PTR_W) begin
         rdata_q <= rx_mem[i_addr[`QSW_PTR_W-1:0]];
      end else if (i_addr[`QSW_ADDR_W-1:`QSW_PTR_W] == `QSW_TX_BASE >> `QSW_PTR_W) begin
         rdata_q <= tx_mem[i_addr[`QSW_PTR_W-1:0]];
      end else begin
         rdata_q <= '0;
         case (i_addr)
            `QSW_CTRL0_OFS: begin
               rdata_q[`QSW_BITS_MSB:`QSW_BITS_LSB] <= bits_q;
               rdata_q[`QSW_CLOCK_PHASE_BIT_BIT] <= clock_phase_bit_q;
               rdata_q[`QSW_CLOCK_POLARITY_BIT_BIT] <= clock_polarity_bit_q;
               rdata_q[`QSW_MASTER_SELECT_BIT_BIT] <= master_select_bit_q;
            end
            `QSW_CTRL1_OFS: begin
               rdata_q[`QSW_PE_BIT] <= pe_q;
            end
            `QSW_CTRL2_OFS: begin
               rdata_q[`QSW_NEWQ_MSB:`QSW_NEWQ_LSB] <= newq_q;
               rdata_q[`QSW_ENDQ_MSB:`QSW_ENDQ_LSB] <= endq_q;
               rdata_q[`QSW_WRAP_TARGET_SELECT_BIT] <= wrap_target_select_q;
               rdata_q[`QSW_WRAP_ENABLE_BIT] <= wrap_enable_q;
               rdata_q[`QSW_IRQEN_BIT] <= irqen_q;
            end
            `QSW_CTRL3_OFS: begin
               rdata_q[`QSW_HALT_BIT] <= halt_req_q;
            end
            `QSW_STAT_OFS: begin
               rdata_q[`QSW_DONE_BIT] <= done_q;
               rdata_q[`QSW_HALTED_BIT] <= (st_q == QSW_ST_HALT);
               rdata_q[`QSW_CPTQ_MSB:`QSW_CPTQ_LSB] <= cptq_q;
            end
            default: begin
               rdata_q <= '0;
            end
         endcase
      end
   end

   assign o_rdata = rdata_q;
   assign o_miso = miso_q;
   assign o_miso_oe = miso_oe_q;
   assign o_irq = irq_q;
   assign o_port_enable = pe_q;

endmodule : qsw_slave

// File: verif/qsw_slave_assertions.sv
`timescale 1ns/1ps
`include "qsw_cfg.svh"
module qsw_slave_assertions
   import qsw_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [`QSW_ADDR_W-1:0] i_addr,
   input wire logic [`QSW_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [`QSW_DATA_W-1:0] o_rdata,
   input wire logic i_sck,
   input wire logic i_sel_n,
   input wire logic i_mosi,
   input wire logic o_miso,
   input wire logic o_miso_oe,
   input wire logic o_irq,
   input wire logic o_port_enable
);
   logic [3:0] desel_cnt_q;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   // Cycles since select was last low; a flag can only be set by a word under select
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || !i_sel_n) begin
         desel_cnt_q <= 4'h0;
      end else if (desel_cnt_q != 4'hf) begin
         desel_cnt_q <= desel_cnt_q + 4'h1;
      end
   end

   sequence s_arm;
      i_rd && i_addr == `QSW_STAT_OFS ##1 o_rdata[`QSW_DONE_BIT];
   endsequence
   sequence s_clr;
      i_wr && i_addr == `QSW_STAT_OFS && !i_wdata[`QSW_DONE_BIT] && !o_miso_oe;
   endsequence

   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data not zero outside a read answer");
   a_unmapped_zero: assert property (i_rd && i_addr > `QSW_STAT_OFS |=> o_rdata == '0)
      else $error("unmapped read returned data");
   a_pe_rise_cause: assert property ($rose(o_port_enable) |-> $past(i_wr) &&
      $past(i_addr) == `QSW_CTRL1_OFS && $past(i_wdata[`QSW_PE_BIT]))
      else $error("port enable rose without a software write");
   a_pe_write: assert property (i_wr && i_addr == `QSW_CTRL1_OFS |=>
      o_port_enable == $past(i_wdata[`QSW_PE_BIT]))
      else $error("port enable did not follow its write");
   a_oe_deselect: assert property (i_sel_n [*5] |-> !o_miso_oe)
      else $error("data out driven while not selected");
   a_oe_port_off: assert property (!o_port_enable [*4] |-> !o_miso_oe)
      else $error("data out driven with port disabled");
   a_irq_status: assert property (i_rd && i_addr == `QSW_STAT_OFS && o_irq &&
      !$past(i_wr) |=> o_rdata[`QSW_DONE_BIT])
      else $error("interrupt high while done flag clear");
   a_irq_clear: assert property (s_arm ##[0:2] s_clr |=> ##[0:1] !o_irq)
      else $error("interrupt stayed after read then zero write");
   a_irq_rise: assert property ($rose(o_irq) |-> desel_cnt_q < 4'h8)
      else $error("interrupt rose away from a completed word");
endmodule : qsw_slave_assertions

bind qsw_slave qsw_slave_assertions qsw_slave_assertions_i (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sck(i_sck), .i_sel_n(i_sel_n),
   .i_mosi(i_mosi), .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_irq(o_irq),
   .o_port_enable(o_port_enable));

// File: verif/qsw_spi_mst.sv
`timescale 1ns/1ps
module qsw_spi_mst
   import qsw_pkg::*;
(
   output logic o_sck,
   output logic o_sel_n,
   output logic o_mosi,
   input wire logic i_miso
);
   localparam int HALF_NS = 40;
   localparam int GAP_NS = 1000;
   logic clock_polarity_bit = 1'b0;
   logic clock_phase_bit = 1'b0;

   initial begin
      o_sck = 1'b0;
      o_sel_n = 1'b1;
      o_mosi = 1'b0;
   end

   // Only between frames, so the idle level never makes a stray edge under select
   task automatic set_mode(input logic pol, input logic pha);
      clock_polarity_bit = pol;
      clock_phase_bit = pha;
      o_sck = pol;
   endtask : set_mode

   task automatic shift(input int n, input qsw_word_t tx, output qsw_word_t rx);
      rx = '0;
      // Off the system clock edges, so pins never race the synchronisers
      #1;
      o_sel_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         if (!clock_phase_bit) begin
            o_mosi = tx[i];
         end
         #(HALF_NS);
         o_sck = ~clock_polarity_bit;
         if (clock_phase_bit) begin
            o_mosi = tx[i];
         end else begin
            rx = {rx[14:0], i_miso};
         end
         #(HALF_NS);
         o_sck = clock_polarity_bit;
         if (clock_phase_bit) begin
            rx = {rx[14:0], i_miso};
         end
      end
      #(HALF_NS);
      o_sel_n = 1'b1;
      // No pull on the line, so a released bit must not look held
      o_mosi = ~o_mosi;
      #(GAP_NS);
   endtask : shift
endmodule : qsw_spi_mst

// File: verif/tb.sv
`timescale 1ns/1ps
`include "qsw_cfg.svh"
module tb
   import qsw_pkg::*;
;
   localparam logic [5:0] RX = `QSW_RX_BASE;
   localparam logic [5:0] C0 = `QSW_CTRL0_OFS;
   localparam logic [5:0] C1 = `QSW_CTRL1_OFS;
   localparam logic [5:0] C2 = `QSW_CTRL2_OFS;
   localparam logic [5:0] C3 = `QSW_CTRL3_OFS;
   localparam logic [5:0] ST = `QSW_STAT_OFS;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] addr = '0;
   qsw_word_t wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   qsw_word_t rdata, got, txw, keep;
   logic sck, sel_n, mosi, miso, miso_oe, irq, pe;
   int fails = 0;
   int tests_run = 0;

   always #2.5 clk = ~clk;

   qsw_slave qsw_slave_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sck(sck), .i_sel_n(sel_n), .i_mosi(mosi),
      .o_miso(miso), .o_miso_oe(miso_oe), .o_irq(irq), .o_port_enable(pe));
   qsw_spi_mst qsw_spi_mst_i (.o_sck(sck), .o_sel_n(sel_n), .o_mosi(mosi), .i_miso(miso));

   task automatic chk(input string what, input qsw_word_t exp, input qsw_word_t seen);
      tests_run++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         fails++;
      end
   endtask : chk
   task automatic bc(input string what, input logic exp, input logic seen);
      chk(what, {15'h0000, exp}, {15'h0000, seen});
   endtask : bc
   task automatic w(input logic [5:0] a, input qsw_word_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : w
   task automatic r(input logic [5:0] a, output qsw_word_t d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : r
   task automatic rc(input string what, input logic [5:0] a, input qsw_word_t exp,
      input qsw_word_t mask);
      qsw_word_t d;
      r(a, d);
      chk(what, exp, d & mask);
   endtask : rc
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task automatic clr_done();
      r(ST, got);
      w(ST, 16'h0000);
      settle();
   endtask : clr_done
   // Flags are {irq enable, wrap enable, wrap to new pointer}
   function automatic qsw_word_t ctl2(input logic [3:0] nq, eq, input logic [2:0] f);
      return {f, 1'b0, eq, 4'h0, nq};
   endfunction : ctl2
   task automatic test_done();
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   initial begin
      #400000;
      fails++;
      test_done();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rc("ctrl0", C0, 16'h0008, 16'hffff);
      rc("status", ST, 16'h0000, 16'hffff);
      rc("unmapped", 6'h3f, 16'h0000, 16'hffff);
      for (int m = 0; m < 4; m++) begin
         txw = 16'h9ac3 + 16'(m);
         w(`QSW_TX_BASE, txw);
         w(C0, {10'h000, m[1], m[0], 4'h0});
         w(C2, ctl2(4'h0, 4'h0, 3'b100));
         qsw_spi_mst_i.set_mode(m[1], m[0]);
         w(C1, 16'h0001);
         qsw_spi_mst_i.shift(16, ~txw, got);
         chk("miso word", txw, got);
         rc("rx word", RX, ~txw, 16'hffff);
         bc("pe", 1'b0, pe);
         bc("irq", 1'b1, irq);
         w(ST, 16'h0000);
         settle();
         bc("irq", 1'b1, irq);
         rc("status", ST, 16'h0001, 16'h0f01);
         w(ST, 16'h0000);
         settle();
         bc("irq", 1'b0, irq);
      end
      w(C0, 16'h0008);
      qsw_spi_mst_i.set_mode(1'b0, 1'b0);
      w(C2, ctl2(4'h1, 4'h2, 3'b111));
      w(C1, 16'h0001);
      qsw_spi_mst_i.shift(5, 16'h0015, got);
      qsw_spi_mst_i.shift(3, 16'h0003, got);
      rc("resumed", RX + 6'h01, 16'h00ab, 16'h00ff);
      qsw_spi_mst_i.shift(8, 16'h005c, got);
      bc("pe", 1'b1, pe);
      bc("irq", 1'b1, irq);
      qsw_spi_mst_i.shift(8, 16'h003e, got);
      rc("wrapped", RX + 6'h01, 16'h003e, 16'h00ff);
      rc("entry two", RX + 6'h02, 16'h005c, 16'h00ff);
      w(C2, ctl2(4'h1, 4'h2, 3'b110));
      qsw_spi_mst_i.shift(8, 16'h0041, got);
      qsw_spi_mst_i.shift(8, 16'h0042, got);
      qsw_spi_mst_i.shift(8, 16'h0044, got);
      rc("wrap to zero", RX, 16'h0044, 16'h00ff);
      w(C2, ctl2(4'h1, 4'h2, 3'b000));
      settle();
      bc("irq", 1'b1, irq);
      clr_done();
      qsw_spi_mst_i.shift(8, 16'h0011, got);
      qsw_spi_mst_i.shift(8, 16'h0022, got);
      bc("pe", 1'b0, pe);
      bc("irq", 1'b0, irq);
      rc("status", ST, 16'h0201, 16'h0f01);
      qsw_spi_mst_i.shift(8, 16'h0077, got);
      rc("discarded", RX + 6'h01, 16'h0011, 16'h00ff);
      clr_done();
      r(RX + 6'h01, keep);
      w(C0, 16'h0000);
      w(C2, ctl2(4'h0, 4'h3, 3'b010));
      w(C1, 16'h0001);
      qsw_spi_mst_i.shift(8, 16'h00c3, got);
      w(C3, 16'h0001);
      qsw_spi_mst_i.shift(8, 16'h005a, got);
      rc("halt word", RX, 16'hc35a, 16'hffff);
      rc("halted", ST, 16'h0002, 16'h0002);
      qsw_spi_mst_i.shift(16, 16'h1234, got);
      rc("held", RX + 6'h01, keep, 16'hffff);
      w(C3, 16'h0000);
      fork
         qsw_spi_mst_i.shift(16, 16'hf0f0, got);
         begin
            #600;
            w(C1, 16'h0000);
            settle();
            bc("pe", 1'b0, pe);
            bc("miso oe", 1'b0, miso_oe);
         end
      join
      rc("aborted", RX + 6'h01, keep, 16'hffff);
      w(C0, 16'h0080);
      w(C1, 16'h0001);
      w(RX, 16'h0000);
      fork
         qsw_spi_mst_i.shift(16, 16'h0ff0, got);
         begin
            #601;
            bc("miso oe", 1'b0, miso_oe);
         end
      join
      rc("master off", RX, 16'hc35a, 16'hffff);
      test_done();
   end
endmodule : tb
